/* mfp_map.sv */
`timescale 1ns/1ps

// Functional notes
// - Code 0x40 input drives loop power-down
// - Codes 0x41/0x42 force free-run, holdover
// - Code 0x43 clears tuning word history
// - Code 0x44 requests distribution divider sync
// - Codes 0x45-0x47 drive profile select bits
// - Codes 0x50-0x58 mute or reset pair drivers
// - Codes 0x59/0x5A mute, reset all drivers
// - Status 0x33 shows loop calibration busy
// - Status 0x34 ORs channel-zero active bits
// - Status 0x35-0x37 free-run, holdover, switching
// - Status 0x38/0x3A/0x3B history, clamp, slew
// - Status 0x39 outputs history updated event
// - Status 0x3C/0x3E sync, phase step events
// - Status 0x3F/0x40 fast acquisition states
// - Status 0x41 feedback divider resync event
// - Status 0x42/0x43 OR slew enables, errors
// - Status 0x50-0x53 channel-one lock states
// - Status 0x54 ORs channel-one active bits
// - Status 0x55-0x57 channel-one loop states
// - Status 0x58/0x5A/0x59 channel-one history, clamp
// - Code 0x5B slew-limited status, N-shot control
module mfp_map
    import mfp_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [MFP_NUM_PINS-1:0] mfp_in,
    output logic      [MFP_NUM_PINS-1:0] mfp_out,
    output logic      [MFP_NUM_PINS-1:0] mfp_oe,
    input  wire logic [7:0]              ch0_lock_status,
    input  wire logic [5:0]              ch0_active_src,
    input  wire logic [2:0]              ch0_loop_state,
    input  wire logic [7:0]              ch0_tune_status,
    input  wire logic [5:0]              ch0_dist_slew_en,
    input  wire logic [5:0]              ch0_dist_cfg_err,
    input  wire logic [7:0]              ch1_lock_status,
    input  wire logic [5:0]              ch1_active_src,
    input  wire logic [2:0]              ch1_loop_state,
    input  wire logic [7:0]              ch1_tune_status,
    input  wire logic                    ch0_hist_upd_evt,
    input  wire logic                    ch0_dist_sync_evt,
    input  wire logic                    ch0_phase_step_evt,
    input  wire logic                    ch0_fb_resync_evt,
    input  wire logic                    ch1_hist_upd_evt,
    output logic                         loop_pd,
    output logic                         force_freerun,
    output logic                         force_holdover,
    output logic                         clear_history,
    output logic                         dist_sync_req,
    output logic      [2:0]              profile_sel,
    output logic      [2:0]              pair_mute_first,
    output logic      [2:0]              pair_mute_second,
    output logic      [2:0]              pair_driver_reset,
    output logic                         mute_all,
    output logic                         reset_all,
    output logic                         nshot_req
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [MFP_CODE_NUM-1:0] code_onehot(
        input logic [MFP_CODE_W-1:0] code
    );
        code_onehot = {{(MFP_CODE_NUM-1){1'b0}}, 1'b1} << code;
    endfunction

    function automatic logic is_cfg_addr(input logic [11:0] addr);
        is_cfg_addr = (addr == MFP_OFS_CFG0) || (addr == MFP_OFS_CFG1) ||
                      (addr == MFP_OFS_CFG2) || (addr == MFP_OFS_CFG3);
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]                cfg_reg [MFP_NUM_PINS];
    logic [MFP_NUM_PINS-1:0]   pin_sync;
    logic [MFP_CODE_NUM-1:0]   stat_vec;
    logic [MFP_CODE_NUM-1:0]   ctrl_vec;

    logic [MFP_CTRL_NUM-1:0]   proxy_next;
    logic [MFP_CTRL_NUM-1:0]   proxy_reg;

    logic [31:0]               rd_next;
    logic [31:0]               rd_reg;
    logic                      err_next;
    logic                      err_reg;

    logic                      setup_phase;
    logic                      wr_access;
    logic [1:0]                wr_index;

    // ************************************************************
    // APB slave
    // ************************************************************
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    assign wr_index    = paddr[3:2];
    assign pready      = 1'b1;
    assign prdata      = rd_reg;
    assign pslverr     = psel && penable && err_reg;

    // ************************************************************
    // Read data and error
    // ************************************************************
    always_comb begin
        rd_next  = 32'h0000_0000;
        err_next = 1'b0;
        if (is_cfg_addr(paddr)) begin
            rd_next[7:0] = cfg_reg[paddr[3:2]];
        end else if (paddr == MFP_OFS_LEVEL) begin
            rd_next[MFP_LVL_IN_LSB  +: MFP_NUM_PINS] = pin_sync;
            rd_next[MFP_LVL_OUT_LSB +: MFP_NUM_PINS] = mfp_out;
            rd_next[MFP_LVL_OE_LSB  +: MFP_NUM_PINS] = mfp_oe;
        end else if (paddr == MFP_OFS_PROXY) begin
            rd_next[MFP_CTRL_NUM-1:0] = proxy_reg;
        end else begin
            err_next = 1'b1;
        end
        if (pwrite) begin
            rd_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_reg  <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (setup_phase) begin
            rd_reg  <= rd_next;
            err_reg <= err_next;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < MFP_NUM_PINS; i++) begin
                cfg_reg[i] <= MFP_CFG_RESET;
            end
        end else if (wr_access && is_cfg_addr(paddr) && pstrb[0]) begin
            cfg_reg[wr_index] <= pwdata[7:0];
        end
    end

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    // sync before use
    mfp_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (mfp_in),
        .q       (pin_sync)
    );

    // ************************************************************
    // Status source map
    // ************************************************************
    always_comb begin
        stat_vec = '0;

        stat_vec[MFP_S_CH0_CAL] = ch0_lock_status[MFP_B_CAL];

        stat_vec[MFP_S_CH0_ACTIVE] = |ch0_active_src;

        stat_vec[MFP_S_CH0_STATE0 +: 3] = ch0_loop_state;

        stat_vec[MFP_S_CH0_HIST]    = ch0_tune_status[MFP_B_HIST];
        stat_vec[MFP_S_CH0_CLAMP]   = ch0_tune_status[MFP_B_CLAMP];
        stat_vec[MFP_S_CH0_SLEWLIM] = ch0_tune_status[MFP_B_SLEWLIM];

        stat_vec[MFP_S_CH0_HIST_EV] = ch0_hist_upd_evt;

        stat_vec[MFP_S_CH0_DSYNC_EV] = ch0_dist_sync_evt;
        stat_vec[MFP_S_CH0_PSTEP_EV] = ch0_phase_step_evt;

        stat_vec[MFP_S_CH0_FA_ACT]  = ch0_tune_status[MFP_B_FA_ACT];
        stat_vec[MFP_S_CH0_FA_DONE] = ch0_tune_status[MFP_B_FA_DONE];

        stat_vec[MFP_S_CH0_FBRS_EV] = ch0_fb_resync_evt;

        stat_vec[MFP_S_CH0_DSLEW]   = |ch0_dist_slew_en;
        stat_vec[MFP_S_CH0_DCFGERR] = |ch0_dist_cfg_err;

        stat_vec[MFP_S_CH1_LOCK0 +: 4] = ch1_lock_status[MFP_B_LOCK_LSB +: 4];

        stat_vec[MFP_S_CH1_ACTIVE] = |ch1_active_src;

        stat_vec[MFP_S_CH1_STATE0 +: 3] = ch1_loop_state;

        stat_vec[MFP_S_CH1_HIST]    = ch1_tune_status[MFP_B_HIST];
        stat_vec[MFP_S_CH1_HIST_EV] = ch1_hist_upd_evt;
        stat_vec[MFP_S_CH1_CLAMP]   = ch1_tune_status[MFP_B_CLAMP];

        stat_vec[MFP_S_CH1_SLEWLIM] = ch1_tune_status[MFP_B_SLEWLIM];
    end

    // ************************************************************
    // Status pin drivers
    // ************************************************************
    generate
        for (genvar p = 0; p < MFP_NUM_PINS; p++) begin : g_out
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mfp_out[p] <= 1'b0;
                    mfp_oe[p]  <= 1'b0;
                end else begin
                    mfp_oe[p] <= cfg_reg[p][MFP_CFG_DIR_BIT];
                    mfp_out[p] <= cfg_reg[p][MFP_CFG_DIR_BIT] &&
                        stat_vec[cfg_reg[p][MFP_CFG_CODE_LSB +: MFP_CODE_W]];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Control decode
    // ************************************************************
    always_comb begin
        ctrl_vec = '0;
        for (int p = 0; p < MFP_NUM_PINS; p++) begin
            if (!cfg_reg[p][MFP_CFG_DIR_BIT] && pin_sync[p]) begin
                ctrl_vec = ctrl_vec |
                    code_onehot(cfg_reg[p][MFP_CFG_CODE_LSB +: MFP_CODE_W]);
            end
        end
    end

    // ************************************************************
    // Proxy selection
    // ************************************************************
    always_comb begin
        proxy_next = '0;

        proxy_next[0] = ctrl_vec[MFP_C_LOOP_PD];

        proxy_next[1] = ctrl_vec[MFP_C_FREERUN];
        proxy_next[2] = ctrl_vec[MFP_C_HOLDOVER];

        proxy_next[3] = ctrl_vec[MFP_C_CLR_HIST];

        proxy_next[4] = ctrl_vec[MFP_C_DIST_SYNC];

        proxy_next[7:5] = ctrl_vec[MFP_C_PROFILE0 +: 3];

        proxy_next[16:8] = ctrl_vec[MFP_C_PAIR_BASE +: 9];

        proxy_next[17] = ctrl_vec[MFP_C_MUTE_ALL];
        proxy_next[18] = ctrl_vec[MFP_C_RESET_ALL];

        proxy_next[19] = ctrl_vec[MFP_C_NSHOT];
    end

    // ************************************************************
    // Proxy register
    // ************************************************************
    // others have no effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proxy_reg <= '0;
        end else begin
            proxy_reg <= proxy_next;
        end
    end

    // ************************************************************
    // Proxy outputs
    // ************************************************************
    // power-down output
    assign loop_pd        = proxy_reg[0];

    assign force_freerun  = proxy_reg[1];
    assign force_holdover = proxy_reg[2];

    assign clear_history  = proxy_reg[3];

    assign dist_sync_req  = proxy_reg[4];

    assign profile_sel    = proxy_reg[7:5];

    assign mute_all       = proxy_reg[17];
    assign reset_all      = proxy_reg[18];

    assign nshot_req      = proxy_reg[19];

    // ************************************************************
    // Pair driver outputs
    // ************************************************************
    generate
        for (genvar k = 0; k < 3; k++) begin : g_pair
            assign pair_mute_first[k]   = proxy_reg[8 + 3*k];
            assign pair_mute_second[k]  = proxy_reg[9 + 3*k];
            assign pair_driver_reset[k] = proxy_reg[10 + 3*k];
        end
    endgenerate

endmodule

/* mfp_pkg.sv */
package mfp_pkg;

    // ************************************************************
    // Structure
    // ************************************************************
    localparam int unsigned MFP_NUM_PINS  = 4;
    localparam int unsigned MFP_CODE_W    = 7;
    localparam int unsigned MFP_CODE_NUM  = 128;
    localparam int unsigned MFP_CTRL_NUM  = 20;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] MFP_OFS_CFG0  = 12'h000;
    localparam logic [11:0] MFP_OFS_CFG1  = 12'h004;
    localparam logic [11:0] MFP_OFS_CFG2  = 12'h008;
    localparam logic [11:0] MFP_OFS_CFG3  = 12'h00c;
    localparam logic [11:0] MFP_OFS_LEVEL = 12'h010;
    localparam logic [11:0] MFP_OFS_PROXY = 12'h014;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int unsigned MFP_CFG_CODE_LSB = 0;
    localparam int unsigned MFP_CFG_DIR_BIT  = 7;
    localparam logic [7:0]  MFP_CFG_RESET    = 8'h00;
    localparam int unsigned MFP_LVL_IN_LSB   = 0;
    localparam int unsigned MFP_LVL_OUT_LSB  = 4;
    localparam int unsigned MFP_LVL_OE_LSB   = 8;

    // ************************************************************
    // Control selector codes
    // ************************************************************
    localparam logic [6:0] MFP_C_LOOP_PD    = 7'h40;
    localparam logic [6:0] MFP_C_FREERUN    = 7'h41;
    localparam logic [6:0] MFP_C_HOLDOVER   = 7'h42;
    localparam logic [6:0] MFP_C_CLR_HIST   = 7'h43;
    localparam logic [6:0] MFP_C_DIST_SYNC  = 7'h44;
    localparam logic [6:0] MFP_C_PROFILE0   = 7'h45;
    localparam logic [6:0] MFP_C_PAIR_BASE  = 7'h50;
    localparam logic [6:0] MFP_C_MUTE_ALL   = 7'h59;
    localparam logic [6:0] MFP_C_RESET_ALL  = 7'h5a;
    localparam logic [6:0] MFP_C_NSHOT      = 7'h5b;

    // ************************************************************
    // Status selector codes
    // ************************************************************
    localparam logic [6:0] MFP_S_CH0_CAL      = 7'h33;
    localparam logic [6:0] MFP_S_CH0_ACTIVE   = 7'h34;
    localparam logic [6:0] MFP_S_CH0_STATE0   = 7'h35;
    localparam logic [6:0] MFP_S_CH0_HIST     = 7'h38;
    localparam logic [6:0] MFP_S_CH0_HIST_EV  = 7'h39;
    localparam logic [6:0] MFP_S_CH0_CLAMP    = 7'h3a;
    localparam logic [6:0] MFP_S_CH0_SLEWLIM  = 7'h3b;
    localparam logic [6:0] MFP_S_CH0_DSYNC_EV = 7'h3c;
    localparam logic [6:0] MFP_S_CH0_PSTEP_EV = 7'h3e;
    localparam logic [6:0] MFP_S_CH0_FA_ACT   = 7'h3f;
    localparam logic [6:0] MFP_S_CH0_FA_DONE  = 7'h40;
    localparam logic [6:0] MFP_S_CH0_FBRS_EV  = 7'h41;
    localparam logic [6:0] MFP_S_CH0_DSLEW    = 7'h42;
    localparam logic [6:0] MFP_S_CH0_DCFGERR  = 7'h43;
    localparam logic [6:0] MFP_S_CH1_LOCK0    = 7'h50;
    localparam logic [6:0] MFP_S_CH1_ACTIVE   = 7'h54;
    localparam logic [6:0] MFP_S_CH1_STATE0   = 7'h55;
    localparam logic [6:0] MFP_S_CH1_HIST     = 7'h58;
    localparam logic [6:0] MFP_S_CH1_HIST_EV  = 7'h59;
    localparam logic [6:0] MFP_S_CH1_CLAMP    = 7'h5a;
    localparam logic [6:0] MFP_S_CH1_SLEWLIM  = 7'h5b;

    // ************************************************************
    // Source bit positions in status words
    // ************************************************************
    localparam int unsigned MFP_B_CAL      = 4;
    localparam int unsigned MFP_B_LOCK_LSB = 1;
    localparam int unsigned MFP_B_HIST     = 0;
    localparam int unsigned MFP_B_CLAMP    = 1;
    localparam int unsigned MFP_B_SLEWLIM  = 2;
    localparam int unsigned MFP_B_FA_ACT   = 4;
    localparam int unsigned MFP_B_FA_DONE  = 5;

endpackage

/* mfp_sync.sv */
`timescale 1ns/1ps

module mfp_sync
    import mfp_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [MFP_NUM_PINS-1:0] d,
    output logic      [MFP_NUM_PINS-1:0] q
);

    // ************************************************************
    // Two stage synchroniser
    // ************************************************************
    logic [MFP_NUM_PINS-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

/* mfp_checker.sv */
`timescale 1ns/1ps

module mfp_checker
    import mfp_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [MFP_NUM_PINS-1:0] mfp_in,
    input wire logic [MFP_NUM_PINS-1:0] mfp_out,
    input wire logic [MFP_NUM_PINS-1:0] mfp_oe,
    input wire logic [7:0]              ch0_lock_status,
    input wire logic [5:0]              ch0_active_src,
    input wire logic                    ch0_hist_upd_evt,
    input wire logic                    loop_pd,
    input wire logic [2:0]              profile_sel
);
    // ************************************************************
    // Shadow of the pin configuration
    // ************************************************************
    logic [7:0] cfg_reg [4];
    logic [2:0] cnt_reg;
    logic       wr_cfg;
    logic       quiet;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_cfg = psel && penable && pwrite && pstrb[0]
                    && paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00;
    assign quiet = cnt_reg == 3'h7 && cfg_reg[1] == 8'h00
                   && cfg_reg[2] == 8'h00 && cfg_reg[3] == 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= '{default: 8'h00};
            cnt_reg <= 3'h0;
        end else if (wr_cfg) begin
            cfg_reg[paddr[3:2]] <= pwdata[7:0];
            cnt_reg <= 3'h0;
        end else if (cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
    // ************************************************************
    // Pin checks
    // ************************************************************
    chk_dir_to_oe: assert property (mfp_oe[0] == $past(cfg_reg[0][7]))
        else $error("pin enable does not follow direction");
    chk_ctrl_pin_low: assert property (!$past(cfg_reg[0][7]) |-> !mfp_out[0])
        else $error("control pin drives high");
    chk_cal_status: assert property ($past(cfg_reg[0]) == 8'hb3 |->
        mfp_out[0] == $past(ch0_lock_status[4])) else $error("cal status");
    chk_active_or: assert property ($past(cfg_reg[0]) == 8'hb4 |->
        mfp_out[0] == |$past(ch0_active_src)) else $error("active status");
    chk_hist_event: assert property ($past(cfg_reg[0]) == 8'hb9 |->
        mfp_out[0] == $past(ch0_hist_upd_evt)) else $error("history event");
    chk_unused_low: assert property ($past(cfg_reg[0]) == 8'hbd |->
        !mfp_out[0]) else $error("unassigned status high");
    chk_pd_proxy: assert property (quiet && cfg_reg[0] == 8'h40 |->
        loop_pd == $past(mfp_in[0], 3)) else $error("power-down proxy");
    chk_profile_msb: assert property (quiet && cfg_reg[0] == 8'h47 |->
        profile_sel == {$past(mfp_in[0], 3), 2'b00}) else $error("profile");
    cover property (cfg_reg[0] == 8'hb4 && mfp_out[0]);
    cover property (quiet && $rose(loop_pd));
    cover property (quiet && profile_sel[2]);
endmodule

bind mfp_map mfp_checker mfp_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .mfp_in(mfp_in), .mfp_out(mfp_out), .mfp_oe(mfp_oe),
    .ch0_lock_status(ch0_lock_status), .ch0_active_src(ch0_active_src),
    .ch0_hist_upd_evt(ch0_hist_upd_evt), .loop_pd(loop_pd),
    .profile_sel(profile_sel)
);

/* mfp_board.sv */
`timescale 1ns/1ps

module mfp_board
    import mfp_pkg::*;
(
    input  wire logic [MFP_NUM_PINS-1:0] drive_val,
    input  wire logic [MFP_NUM_PINS-1:0] mfp_out,
    input  wire logic [MFP_NUM_PINS-1:0] mfp_oe,
    output logic      [MFP_NUM_PINS-1:0] mfp_in
);
    // Board drives only pins the device has released
    always_comb begin
        for (int i = 0; i < MFP_NUM_PINS; i++) begin
            mfp_in[i] = mfp_oe[i] ? mfp_out[i] : drive_val[i];
        end
    end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps

module tb_top
    import mfp_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [66:0] src = 67'h0;
    logic [3:0]  drv = 4'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, loop_pd, mute_all, reset_all;
    logic        force_freerun, force_holdover, clear_history;
    logic        dist_sync_req, nshot_req;
    logic [3:0]  mfp_in, mfp_out, mfp_oe;
    logic [2:0]  profile_sel, pair_mute_first, pair_mute_second;
    logic [2:0]  pair_driver_reset;
    logic [19:0] proxy_vec;
    int          n_fail = 0;
    int          n_compared = 0;
    localparam logic [15:0] ST_ROWS [32] = '{
        16'h3304, 16'h340d, 16'h3408, 16'h350e, 16'h360f, 16'h3710,
        16'h3811, 16'h3a12, 16'h3b13, 16'h393e, 16'h3c3f, 16'h3e40,
        16'h3f15, 16'h4016, 16'h4141, 16'h421e, 16'h4219, 16'h4324,
        16'h431f, 16'h5026, 16'h5127, 16'h5228, 16'h5329, 16'h5432,
        16'h542d, 16'h5533, 16'h5634, 16'h5735, 16'h5836, 16'h5a37,
        16'h5942, 16'h5b38};
    localparam logic [15:0] CT_ROWS [20] = '{
        16'h4000, 16'h4101, 16'h4202, 16'h4303, 16'h4404, 16'h4505,
        16'h4606, 16'h4707, 16'h5008, 16'h5109, 16'h520a, 16'h530b,
        16'h540c, 16'h550d, 16'h560e, 16'h570f, 16'h5810, 16'h5911,
        16'h5a12, 16'h5b13};
    localparam logic [7:0] UN_ROWS [4] = '{8'h3d, 8'h48, 8'h4f, 8'h7f};

    assign proxy_vec = {nshot_req, reset_all, mute_all,
        pair_driver_reset[2], pair_mute_second[2], pair_mute_first[2],
        pair_driver_reset[1], pair_mute_second[1], pair_mute_first[1],
        pair_driver_reset[0], pair_mute_second[0], pair_mute_first[0],
        profile_sel, dist_sync_req, clear_history, force_holdover,
        force_freerun, loop_pd};
    always #12.5 pclk = ~pclk;

    mfp_map mfp_map_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mfp_in(mfp_in), .mfp_out(mfp_out), .mfp_oe(mfp_oe),
        .ch0_lock_status(src[7:0]), .ch0_active_src(src[13:8]),
        .ch0_loop_state(src[16:14]), .ch0_tune_status(src[24:17]),
        .ch0_dist_slew_en(src[30:25]), .ch0_dist_cfg_err(src[36:31]),
        .ch1_lock_status(src[44:37]), .ch1_active_src(src[50:45]),
        .ch1_loop_state(src[53:51]), .ch1_tune_status(src[61:54]),
        .ch0_hist_upd_evt(src[62]), .ch0_dist_sync_evt(src[63]),
        .ch0_phase_step_evt(src[64]), .ch0_fb_resync_evt(src[65]),
        .ch1_hist_upd_evt(src[66]), .loop_pd(loop_pd),
        .force_freerun(force_freerun), .force_holdover(force_holdover),
        .clear_history(clear_history), .dist_sync_req(dist_sync_req),
        .profile_sel(profile_sel), .pair_mute_first(pair_mute_first),
        .pair_mute_second(pair_mute_second), .mute_all(mute_all),
        .pair_driver_reset(pair_driver_reset), .reset_all(reset_all),
        .nshot_req(nshot_req));
    mfp_board mfp_board_inst (.drive_val(drv), .mfp_out(mfp_out),
        .mfp_oe(mfp_oe), .mfp_in(mfp_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        finish_test();
    end

    initial begin
        logic [7:0] code;
        logic       or_row;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 32; r++) begin
            code = ST_ROWS[r][15:8];
            or_row = code inside {8'h34, 8'h42, 8'h43, 8'h54};
            apb(1'b1, MFP_OFS_CFG0, {24'h0, 1'b1, code[6:0]}, 4'hf);
            src <= 67'h1 << ST_ROWS[r][7:0];
            repeat (3) @(posedge pclk);
            chk({30'h0, mfp_oe[0], mfp_out[0]}, 32'h3);
            src <= ~(67'h1 << ST_ROWS[r][7:0]);
            repeat (3) @(posedge pclk);
            chk({30'h0, mfp_oe[0], mfp_out[0]}, {31'h1, or_row});
            src <= 67'h0;
            repeat (3) @(posedge pclk);
            chk({30'h0, mfp_oe[0], mfp_out[0]}, 32'h2);
        end
        src <= 67'h0;
        for (int r = 0; r < 20; r++) begin
            apb(1'b1, MFP_OFS_CFG0, {24'h0, CT_ROWS[r][15:8]}, 4'hf);
            drv <= 4'h1;
            repeat (6) @(posedge pclk);
            chk({12'h0, proxy_vec}, 32'h1 << CT_ROWS[r][7:0]);
            drv <= 4'h0;
            repeat (6) @(posedge pclk);
            chk({12'h0, proxy_vec}, 32'h0);
        end
        src <= ~67'h0;
        drv <= 4'hf;
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, MFP_OFS_CFG0, {24'h0, 1'b1, UN_ROWS[r][6:0]}, 4'hf);
            repeat (3) @(posedge pclk);
            chk({31'h0, mfp_out[0]}, 32'h0);
            apb(1'b1, MFP_OFS_CFG0, {24'h0, UN_ROWS[r]}, 4'hf);
            repeat (6) @(posedge pclk);
            chk({12'h0, proxy_vec}, 32'h0);
        end
        src <= 67'h0;
        drv <= 4'h0;
        apb(1'b1, MFP_OFS_CFG1, 32'h59, 4'hf);
        apb(1'b1, MFP_OFS_CFG2, 32'h59, 4'hf);
        repeat (6) @(posedge pclk);
        drv <= 4'h4;
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, mute_all}, 32'h0);
        @(posedge pclk);
        #1;
        chk({31'h0, mute_all}, 32'h1);
        apb(1'b0, MFP_OFS_PROXY, 32'h0, 4'h0);
        chk(rd, 32'h0002_0000);
        apb(1'b0, MFP_OFS_LEVEL, 32'h0, 4'h0);
        chk(rd, 32'h0000_0004);
        @(posedge pclk);
        drv <= 4'h0;
        apb(1'b1, MFP_OFS_CFG2, 32'h00, 4'hf);
        apb(1'b1, MFP_OFS_CFG1, 32'hffff_ffb3, 4'hf);
        apb(1'b1, MFP_OFS_CFG1, 32'h0000_0000, 4'he);
        apb(1'b0, MFP_OFS_CFG1, 32'h0, 4'h0);
        chk(rd, 32'h0000_00b3);
        apb(1'b0, 12'h018, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({mfp_oe, mfp_out, 3'h0, pready, proxy_vec}, 32'h0010_0000);
        presetn <= 1'b1;
        apb(1'b0, MFP_OFS_CFG1, 32'h0, 4'h0);
        chk(rd, 32'h0);
        finish_test();
    end
endmodule
